// ===== design/rdt_pkg.sv
// Package: constants and types for the relay delay timer
package rdt_pkg;

  // ----------------------------------------
  // Timing counts in rc_timebase periods, counter widths and input count
  // ----------------------------------------
  localparam int unsigned DEBOUNCE_PERIODS = 6;
  localparam int unsigned HOLD_PERIODS     = 73728;
  localparam int          HOLD_W           = 17;
  localparam int          DEB_W            = 3;
  localparam int          NUM_IN           = 3;

  // ----------------------------------------
  // Input bit positions
  // ----------------------------------------
  localparam int IDX_FLIP   = 0;
  localparam int IDX_ACT    = 1;
  localparam int IDX_DEACT  = 2;

  // ----------------------------------------
  // Reset values and last hold count
  // ----------------------------------------
  localparam logic [NUM_IN-1:0] IN_RESET  = 3'h0;
  localparam logic [HOLD_W-1:0] HOLD_LAST = 17'h11FFF;

  // ----------------------------------------
  // Timer states
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE    = 2'b00,
    ST_HOLD    = 2'b01,
    ST_WAITREL = 2'b11
  } rdt_state_e;

endpackage

// ===== design/rdt_debounce.sv
// Shared debounce stage for the three push-button inputs
`timescale 1ns/10ps
module rdt_debounce
  import rdt_pkg::*;
(
  // Clock, reset, enable and timebase tick
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ce,
  input  wire logic              i_tick,
  // Raw and filtered levels
  input  wire logic [NUM_IN-1:0] i_raw,
  output logic      [NUM_IN-1:0] o_level
);

  logic [NUM_IN-1:0] samp_reg;
  logic [DEB_W-1:0]  cnt_reg;
  logic [DEB_W-1:0]  cnt_next;
  wire               differs = (samp_reg != o_level);
  wire               changed = (i_raw != samp_reg);
  wire               settled = (cnt_reg == DEB_W'(DEBOUNCE_PERIODS - 1));

  assign cnt_next = (changed || !differs) ? '0 : cnt_reg + DEB_W'(1);

  // ----------------------------------------
  // Sample and count on each timebase period
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      samp_reg <= IN_RESET;
      cnt_reg  <= '0;
      o_level  <= IN_RESET;
    end
    else if (i_ce && i_tick)
    begin
      samp_reg <= i_raw;
      cnt_reg  <= settled ? '0 : cnt_next;
      if (differs && !changed && settled)
        o_level <= samp_reg;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_deb_stable;
    @(posedge i_clk) disable iff (!i_rst_n)
    $changed(o_level) |-> $past(samp_reg) == o_level && $past(cnt_reg) == 3'h5;
  endproperty
  a_deb_stable: assert property (p_deb_stable) else $error("debounce accepted early");

endmodule

// ===== design/rdt_timer.sv
// Relay delay timer: debounced inputs driving a relay hold interval
// What this block does
// - Debounce interval is six timebase periods.
// - Hold interval is 73728 timebase periods from trigger.
// - Reset puts all logic idle with relay output off.
// - Relay on when triggered, off when hold interval elapses.
// - First accepted flip press in ST_IDLE turns relay on.
// - Flip press while on turns relay off, abandons count.
// - Accepted flip press inverts the relay state, except in ST_WAITREL where relay stays off.
// - Without a flip or deactivate press relay stays on until hold ends.
// - Accepted activate press without a deactivate press turns relay on and starts hold.
// - Accepted deactivate press turns relay off, ends hold.
// - No retrigger; activate while on does not restart count.
// - Held activate still times out and never reactivates.
// - Activate held at power-up triggers exactly one hold.
// - Both press and release edges are debounced.
`timescale 1ns/10ps
module rdt_timer
  import rdt_pkg::*;
(
  // Clock, reset, enable
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_ce,
  // Timebase: one pulse per rc_timebase_pin period
  input  wire logic i_rc_timebase_pin,
  // Push-buttons
  input  wire logic i_flip_pushbutton,
  input  wire logic i_activate,
  input  wire logic i_deactivate,
  // Relay drive, open collector: low enable means coil pulled
  output logic      o_relay_on,
  output logic      o_relay_oe_n,
  output logic      o_hold_running
);

  // ----------------------------------------
  // Debounce
  // ----------------------------------------
  logic [NUM_IN-1:0] lvl;
  logic [NUM_IN-1:0] lvl_reg;
  rdt_state_e        state_reg;
  rdt_state_e        state_next;
  logic [HOLD_W-1:0] hold_reg;

  rdt_debounce u_deb
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_tick  (i_rc_timebase_pin),
    .i_raw   ({i_deactivate, i_activate, i_flip_pushbutton}),
    .o_level (lvl)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire flip_press  = lvl[IDX_FLIP] & ~lvl_reg[IDX_FLIP];
  wire act_press   = lvl[IDX_ACT] & ~lvl_reg[IDX_ACT];
  wire deact_press = lvl[IDX_DEACT] & ~lvl_reg[IDX_DEACT];
  wire running     = (state_reg == ST_HOLD);
  wire hold_done   = running && i_rc_timebase_pin && (hold_reg == HOLD_LAST);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (flip_press || (act_press && !deact_press))
          state_next = ST_HOLD;
      ST_HOLD:
        if (flip_press || deact_press)
          state_next = ST_IDLE;
        else if (hold_done)
          state_next = lvl[IDX_ACT] ? ST_WAITREL : ST_IDLE;
      ST_WAITREL:
        if (!lvl[IDX_ACT] || flip_press)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  // ----------------------------------------
  // State and hold counter
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ST_IDLE;
      lvl_reg   <= IN_RESET;
      hold_reg  <= '0;
    end
    else if (i_ce)
    begin
      state_reg <= state_next;
      lvl_reg   <= lvl;
      if (!running || state_next != ST_HOLD)
        hold_reg <= '0;
      else if (i_rc_timebase_pin)
        hold_reg <= hold_reg + HOLD_W'(1);
    end
  end

  assign o_relay_on     = running;
  assign o_relay_oe_n   = ~running;
  assign o_hold_running = running;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_reset_off;
    @(posedge i_clk) !i_rst_n |-> !o_relay_on;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("relay on in reset");

  property p_hold_len;
    @(posedge i_clk) disable iff (!i_rst_n)
    (running && hold_reg == HOLD_LAST && i_rc_timebase_pin && i_ce && !flip_press
      && !deact_press) |=> !o_relay_on;
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("hold did not end");

  property p_flip_on;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && flip_press && state_reg == ST_IDLE) |=> o_relay_on;
  endproperty
  a_flip_on: assert property (p_flip_on) else $error("flip did not turn on");

  property p_flip_off;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && flip_press && running) |=> !o_relay_on && hold_reg == '0;
  endproperty
  a_flip_off: assert property (p_flip_off) else $error("flip did not turn off");

  property p_deact_off;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && deact_press && running) |=> !o_relay_on;
  endproperty
  a_deact_off: assert property (p_deact_off) else $error("deactivate ignored");

  property p_no_retrig;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && running && act_press && !flip_press && !deact_press && !hold_done
      && i_rc_timebase_pin) |=> hold_reg == $past(hold_reg) + 17'h00001;
  endproperty
  a_no_retrig: assert property (p_no_retrig) else $error("hold restarted");

  property p_held_no_re;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_reg == ST_WAITREL && lvl[IDX_ACT]) |=> !o_relay_on;
  endproperty
  a_held_no_re: assert property (p_held_no_re) else $error("reactivated while held");

  property p_deact_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && deact_press && !act_press && !flip_press && state_reg == ST_IDLE)
      |=> !o_relay_on;
  endproperty
  a_deact_idle: assert property (p_deact_idle) else $error("deactivate acted");

  // ----------------------------------------
  // Enable, tick, counter, output and state checks
  // ----------------------------------------
  property p_ce_freeze;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_ce |=> $stable(state_reg) && $stable(hold_reg) && $stable(lvl);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");

  property p_tick_gate;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && running && !i_rc_timebase_pin && state_next == ST_HOLD) |=> $stable(hold_reg);
  endproperty
  a_tick_gate: assert property (p_tick_gate) else $error("hold counted without tick");

  property p_oe_inv;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_relay_oe_n == !o_relay_on;
  endproperty
  a_oe_inv: assert property (p_oe_inv) else $error("drive enable not inverse");

  property p_hold_start;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && !running && state_next == ST_HOLD) |=> running && hold_reg == '0;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold not started at zero");

  property p_act_on;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && act_press && !deact_press && state_reg == ST_IDLE) |=> o_relay_on;
  endproperty
  a_act_on: assert property (p_act_on) else $error("activate did not turn on");

  property p_waitrel_exit;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && state_reg == ST_WAITREL && !lvl[IDX_ACT]) |=> state_reg == ST_IDLE;
  endproperty
  a_waitrel_exit: assert property (p_waitrel_exit) else $error("release not seen");

  property p_deact_clr;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && deact_press && running) |=> hold_reg == '0;
  endproperty
  a_deact_clr: assert property (p_deact_clr) else $error("hold not abandoned");

  property p_done_held;
    @(posedge i_clk) disable iff (!i_rst_n)
    (i_ce && hold_done && !flip_press && !deact_press && lvl[IDX_ACT])
      |=> state_reg == ST_WAITREL;
  endproperty
  a_done_held: assert property (p_done_held) else $error("held activate not parked");

  c_flip_on:  cover property (@(posedge i_clk) disable iff (!i_rst_n) flip_press ##1 running);
  c_timeout:  cover property (@(posedge i_clk) disable iff (!i_rst_n) hold_done);
  c_waitrel:  cover property (@(posedge i_clk) disable iff (!i_rst_n) state_reg == ST_WAITREL);
  c_deact:    cover property (@(posedge i_clk) disable iff (!i_rst_n) running && deact_press);
  c_freeze:   cover property (@(posedge i_clk) disable iff (!i_rst_n) running && !i_ce);

endmodule

// ===== bench/rdt_panel.sv
// Push-button panel and relay coil model for the relay delay timer
`timescale 1ns/10ps
module rdt_panel
(
  // Clock and relay drive
  input  wire logic i_clk,
  input  wire logic i_relay_oe_n,
  // Button levels and coil state
  output logic      o_flip,
  output logic      o_act,
  output logic      o_deact,
  output logic      o_coil_on
);
  // Coil pulls in while the open collector conducts
  assign o_coil_on = ~i_relay_oe_n;
  initial {o_deact, o_act, o_flip} = 3'h0;
  // Drives all three button levels from btn on a falling clock edge, in any combination
  task automatic set_btn(input logic [2:0] btn);
    @(negedge i_clk);
    {o_deact, o_act, o_flip} = btn;
  endtask
endmodule

// ===== bench/rdt_timer_test.sv
// Testbench for the relay delay timer
`timescale 1ns/10ps
module rdt_timer_test;
  import rdt_pkg::*;
  logic i_clk;
  logic i_rst_n;
  logic relay_on;
  logic relay_oe_n;
  logic hold_running;
  logic coil_on;
  logic flip;
  logic act;
  logic deact;
  int   mismatches;
  int   check_count;
  int   n;
  logic ce;
  logic tick;

  rdt_timer u_rdt_timer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_rc_timebase_pin(tick), .i_flip_pushbutton(flip), .i_activate(act),
    .i_deactivate(deact), .o_relay_on(relay_on), .o_relay_oe_n(relay_oe_n),
    .o_hold_running(hold_running));
  rdt_panel u_rdt_panel (.i_clk(i_clk), .i_relay_oe_n(relay_oe_n), .o_flip(flip),
    .o_act(act), .o_deact(deact), .o_coil_on(coil_on));

  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
    end
  endtask

  task automatic outs(input logic lvl);
    chk("relay_on", {31'h0, relay_on}, {31'h0, lvl});
    chk("relay_oe_n", {31'h0, relay_oe_n}, {31'h0, ~lvl});
    chk("hold_running", {31'h0, hold_running}, {31'h0, lvl});
    chk("coil_on", {31'h0, coil_on}, {31'h0, lvl});
  endtask

  task automatic wait_out(input logic lvl, input int lim);
    n = 0;
    while (relay_on !== lvl && n < lim)
    begin
      @(negedge i_clk);
      n++;
    end
  endtask

  task automatic release_btn();
    u_rdt_panel.set_btn(3'h0);
    repeat (12) @(negedge i_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_power_up();
    u_rdt_panel.set_btn(3'h2);
    outs(1'b0);
    repeat (6) @(negedge i_clk);
    i_rst_n = 1'b1;
    wait_out(1'b1, 20);
    chk("power-up latency", n, 8);
    outs(1'b1);
    wait_out(1'b0, 80000);
    chk("hold length", n, 73728);
    outs(1'b0);
    wait_out(1'b1, 20);
    chk("held activate", n, 20);
    u_rdt_panel.set_btn(3'h0);
    wait_out(1'b1, 20);
    chk("release of activate", n, 20);
    $display("test power_up done");
  endtask

  task automatic test_flip();
    u_rdt_panel.set_btn(3'h1);
    wait_out(1'b1, 20);
    chk("flip on latency", n, 8);
    release_btn();
    outs(1'b1);
    u_rdt_panel.set_btn(3'h1);
    wait_out(1'b0, 20);
    chk("flip off latency", n, 8);
    release_btn();
    u_rdt_panel.set_btn(3'h1);
    repeat (4) @(negedge i_clk);
    u_rdt_panel.set_btn(3'h0);
    wait_out(1'b1, 20);
    chk("short flip glitch", n, 20);
    $display("test flip done");
  endtask

  task automatic test_on_off();
    u_rdt_panel.set_btn(3'h2);
    wait_out(1'b1, 20);
    chk("activate latency", n, 8);
    release_btn();
    u_rdt_panel.set_btn(3'h2);
    wait_out(1'b0, 20);
    chk("activate while on", n, 20);
    release_btn();
    u_rdt_panel.set_btn(3'h4);
    wait_out(1'b0, 20);
    chk("deactivate latency", n, 8);
    release_btn();
    u_rdt_panel.set_btn(3'h4);
    wait_out(1'b1, 20);
    chk("deactivate while off", n, 20);
    release_btn();
    outs(1'b0);
    $display("test on_off done");
  endtask

  task automatic test_gating();
    u_rdt_panel.set_btn(3'h1);
    tick = 1'b0;
    wait_out(1'b1, 10);
    chk("press without ticks", n, 10);
    tick = 1'b1;
    wait_out(1'b1, 20);
    chk("flip on after ticks resume", n, 8);
    release_btn();
    ce = 1'b0;
    u_rdt_panel.set_btn(3'h1);
    wait_out(1'b0, 20);
    chk("flip while frozen", n, 20);
    ce = 1'b1;
    wait_out(1'b0, 20);
    chk("flip off after enable", n, 8);
    release_btn();
    outs(1'b0);
    $display("test gating done");
  endtask

  // ----------------------------------------
  // Verdict and main sequence
  // ----------------------------------------
  task automatic results();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #(100 * 85000);
    mismatches++;
    results();
  end

  initial
  begin
    i_rst_n = 1'b0;
    ce = 1'b1;
    tick = 1'b1;
    mismatches = 0;
    check_count = 0;
    test_power_up();
    test_flip();
    test_on_off();
    test_gating();
    results();
  end
endmodule
